/* File: logic/cpt_pkg.sv */
// Purpose: constants and types for one channel's control register and pattern test
// Assumes: one processor port shared on the REF_CLK domain, 8-bit data
// Notes: tags below mark the logic and checks of each rule
// Function
// - bit 5 enables generator and checker
// - 0 turns both off, 1 both on
// - DS3/STS-1 sends unframed 2^15-1 sequence
// - E3 sends unframed 2^23-1 sequence
// - checker searches rate sequence, then counts errors
// - testing forces single-rail receive output
// - negative/violation pin flags each bit error
// - each error adds to 16-bit counter (code holds the count at all ones)
// - testing replaces transmit pin data by sequence
// - register at low nibble 6, channel nibble high
// - loop fields: normal, remote, analog, digital
// - rate group 1 is E3, else DS3/STS-1
`default_nettype none

package cpt_pkg;

    localparam logic [3:0] CPT_CTRL_LOW_NIBBLE = 4'h6;
    localparam logic [7:0] CPT_CTRL_RESET      = 8'h00;
    localparam logic [7:0] CPT_CTRL_WRITE_MASK = 8'h3f;

    localparam int CPT_TEST_EN_BIT     = 5;
    localparam int CPT_REMOTE_LOOP_BIT = 4;
    localparam int CPT_LOCAL_LOOP_BIT  = 3;
    localparam int CPT_E3_BIT          = 2;
    localparam int CPT_STS_BIT         = 1;
    localparam int CPT_RAIL_FMT_BIT    = 0;

    localparam int CPT_SHORT_LEN    = 15;
    localparam int CPT_SHORT_TAP    = 14;
    localparam int CPT_LONG_LEN     = 23;
    localparam int CPT_LONG_TAP     = 18;

    localparam int          CPT_ERR_WIDTH     = 16;
    localparam logic [5:0]  CPT_LOCK_MATCHES  = 6'h20;
    localparam int          CPT_FIFO_DEPTH    = 8;

    typedef enum logic [3:0] {
        CPT_LOOP_NORMAL  = 4'b0001,
        CPT_LOOP_REMOTE  = 4'b0010,
        CPT_LOOP_ANALOG  = 4'b0100,
        CPT_LOOP_DIGITAL = 4'b1000
    } cpt_loop_t;

    typedef enum logic [2:0] {
        CPT_RATE_DS3  = 3'b001,
        CPT_RATE_STS1 = 3'b010,
        CPT_RATE_E3   = 3'b100
    } cpt_rate_t;

    typedef enum logic [1:0] {
        CPT_SEARCH = 2'b01,
        CPT_LOCKED = 2'b10
    } cpt_chk_state_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } cpt_rail_t;

endpackage : cpt_pkg

`default_nettype wire

/* File: logic/cpt_channel.sv */
// Purpose: channel control register, pattern generator and checker, transmit FIFO
// Assumes: processor port is synchronous to REF_CLK; line clocks are slow pins
// Notes: line clocks are oversampled by REF_CLK and only their rising edges are used
`default_nettype none

module cpt_fifo
    import cpt_pkg::*;
#(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
)(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    always_comb
    begin
        in_ready  = (count != CW'(DEPTH));
        out_valid = (count != '0);
        out_data  = mem[rd_ptr];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push)
        begin
            next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        next_count = count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage needs no reset; empty flag hides stale words
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : cpt_fifo

module cpt_channel
    import cpt_pkg::*;
#(
    parameter logic [3:0] CHANNEL_NIBBLE = 4'h0,
    parameter int         FIFO_DEPTH     = CPT_FIFO_DEPTH
)(
    input  wire logic                     REF_CLK,
    input  wire logic                     RST,
    input  wire logic [7:0]               CPU_ADDR,
    input  wire logic [7:0]               CPU_WDATA,
    input  wire logic                     CPU_WR,
    input  wire logic                     CPU_RD,
    output logic      [7:0]               CPU_RDATA,
    output logic                          CPU_RD_ACK,
    input  wire logic                     TX_LINE_CLOCK,
    input  wire logic                     TX_POSITIVE_DATA,
    input  wire logic                     TX_NEGATIVE_DATA,
    output logic                          TX_READY,
    output logic                          TX_OUT_POS,
    output logic                          TX_OUT_NEG,
    input  wire logic                     RX_REC_CLOCK,
    input  wire logic                     RX_REC_POS,
    input  wire logic                     RX_REC_NEG,
    output logic                          RX_OUT_POS,
    output logic                          RX_NEG_VIOLATION_PIN,
    output logic      [CPT_ERR_WIDTH-1:0] ERROR_COUNT,
    output logic                          PATTERN_LOCKED,
    output cpt_loop_t                     LOOP_MODE,
    output cpt_rate_t                     RATE_MODE
);
    // register and decode
    logic [7:0]  channel_control;
    logic [7:0]  next_channel_control;
    logic [7:0]  next_cpu_rdata;
    logic        next_cpu_rd_ack;
    logic        reg_hit;
    logic        test_pattern_enable;
    logic        europe_rate_group_select;
    logic        rail_format_select;

    // pin synchronisers: index 0 clk, 1 pos, 2 neg
    logic [2:0]  tx_meta;
    logic [2:0]  tx_sync;
    logic        tx_clk_prev;
    logic [2:0]  rx_meta;
    logic [2:0]  rx_sync;
    logic        rx_clk_prev;
    logic        tx_edge;
    logic        rx_edge;

    // transmit path
    logic [CPT_LONG_LEN-1:0] gen;
    logic [CPT_LONG_LEN-1:0] next_gen;
    logic                    gen_bit;
    cpt_rail_t               tx_in_word;
    cpt_rail_t               fifo_word;
    logic                    fifo_valid;
    logic                    fifo_in_valid;
    logic                    fifo_out_ready;
    cpt_rail_t               tx_out;
    cpt_rail_t               next_tx_out;

    // receive path
    logic [CPT_LONG_LEN-1:0]  chk;
    logic [CPT_LONG_LEN-1:0]  next_chk;
    logic                     predicted;
    logic                     mismatch;
    cpt_chk_state_t           chk_state;
    cpt_chk_state_t           next_chk_state;
    logic [5:0]               match_run;
    logic [5:0]               next_match_run;
    logic [CPT_ERR_WIDTH-1:0] err_count;
    logic [CPT_ERR_WIDTH-1:0] next_err_count;
    cpt_rail_t                rx_out;
    cpt_rail_t                next_rx_out;

    assign reg_hit = (CPU_ADDR[7:4] == CHANNEL_NIBBLE) && (CPU_ADDR[3:0] == CPT_CTRL_LOW_NIBBLE);

    assign test_pattern_enable      = channel_control[CPT_TEST_EN_BIT];
    assign europe_rate_group_select = channel_control[CPT_E3_BIT];
    assign rail_format_select       = channel_control[CPT_RAIL_FMT_BIT];

    always_comb
    begin
        next_channel_control = channel_control;
        if (CPU_WR && reg_hit)
        begin
            next_channel_control = CPU_WDATA & CPT_CTRL_WRITE_MASK;
        end
        next_cpu_rd_ack = CPU_RD && reg_hit;
        next_cpu_rdata  = CPU_RDATA;
        if (CPU_RD && reg_hit)
        begin
            next_cpu_rdata = channel_control;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            channel_control <= CPT_CTRL_RESET;
            CPU_RDATA       <= 8'h00;
            CPU_RD_ACK      <= 1'b0;
        end
        else
        begin
            channel_control <= next_channel_control;
            CPU_RDATA       <= next_cpu_rdata;
            CPU_RD_ACK      <= next_cpu_rd_ack;
        end
    end

    always_comb
    begin
        case ({channel_control[CPT_LOCAL_LOOP_BIT], channel_control[CPT_REMOTE_LOOP_BIT]})
            2'b00:   LOOP_MODE = CPT_LOOP_NORMAL;
            2'b01:   LOOP_MODE = CPT_LOOP_REMOTE;
            2'b10:   LOOP_MODE = CPT_LOOP_ANALOG;
            default: LOOP_MODE = CPT_LOOP_DIGITAL;
        endcase
        if (europe_rate_group_select)
        begin
            RATE_MODE = CPT_RATE_E3;
        end
        else if (channel_control[CPT_STS_BIT])
        begin
            RATE_MODE = CPT_RATE_STS1;
        end
        else
        begin
            RATE_MODE = CPT_RATE_DS3;
        end
    end

    // only the second stage and the stored previous clock feed logic
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            tx_meta     <= 3'h0;
            tx_sync     <= 3'h0;
            tx_clk_prev <= 1'b0;
            rx_meta     <= 3'h0;
            rx_sync     <= 3'h0;
            rx_clk_prev <= 1'b0;
        end
        else
        begin
            tx_meta     <= {TX_NEGATIVE_DATA, TX_POSITIVE_DATA, TX_LINE_CLOCK};
            tx_sync     <= tx_meta;
            tx_clk_prev <= tx_sync[0];
            rx_meta     <= {RX_REC_NEG, RX_REC_POS, RX_REC_CLOCK};
            rx_sync     <= rx_meta;
            rx_clk_prev <= rx_sync[0];
        end
    end

    assign tx_edge = tx_sync[0] && !tx_clk_prev;
    assign rx_edge = rx_sync[0] && !rx_clk_prev;

    // relies on a running line clock
    assign tx_in_word.pos = tx_sync[1];
    assign tx_in_word.neg = tx_sync[2];
    assign fifo_in_valid  = tx_edge && !test_pattern_enable;
    assign fifo_out_ready = tx_edge;

    cpt_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (REF_CLK),
        .rst       (RST),
        .in_valid  (fifo_in_valid),
        .in_data   (tx_in_word),
        .in_ready  (TX_READY),
        .out_valid (fifo_valid),
        .out_data  (fifo_word),
        .out_ready (fifo_out_ready)
    );

    always_comb
    begin
        if (europe_rate_group_select)
        begin
            gen_bit   = gen[CPT_LONG_LEN-1] ^ gen[CPT_LONG_TAP-1];
            predicted = chk[CPT_LONG_LEN-1] ^ chk[CPT_LONG_TAP-1];
        end
        else
        begin
            gen_bit   = gen[CPT_SHORT_LEN-1] ^ gen[CPT_SHORT_TAP-1];
            predicted = chk[CPT_SHORT_LEN-1] ^ chk[CPT_SHORT_TAP-1];
        end
        next_gen    = gen;
        next_tx_out = tx_out;
        // disabled generator reseeds; all ones avoids lockup
        if (!test_pattern_enable)
        begin
            next_gen = '1;
        end
        if (tx_edge)
        begin
            if (test_pattern_enable)
            begin
                next_gen        = {gen[CPT_LONG_LEN-2:0], gen_bit};
                next_tx_out.pos = gen_bit;
                next_tx_out.neg = 1'b0;
            end
            else if (fifo_valid)
            begin
                next_tx_out = fifo_word;
            end
            else
            begin
                next_tx_out = '0;
            end
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            gen    <= '1;
            tx_out <= '0;
        end
        else
        begin
            gen    <= next_gen;
            tx_out <= next_tx_out;
        end
    end

    assign TX_OUT_POS = tx_out.pos;
    assign TX_OUT_NEG = tx_out.neg;

    // self-synchronising checker: received bits seed the predictor
    assign mismatch = rx_sync[1] != predicted;

    always_comb
    begin
        next_chk       = chk;
        next_chk_state = chk_state;
        next_match_run = match_run;
        next_err_count = err_count;
        next_rx_out    = rx_out;
        if (rx_edge)
        begin
            next_chk = {chk[CPT_LONG_LEN-2:0], rx_sync[1]};
            if (test_pattern_enable)
            begin
                next_rx_out.pos = rx_sync[1];
                next_rx_out.neg = 1'b0;
            end
            else if (rail_format_select)
            begin
                next_rx_out.pos = rx_sync[1];
                next_rx_out.neg = 1'b0;
            end
            else
            begin
                next_rx_out.pos = rx_sync[1];
                next_rx_out.neg = rx_sync[2];
            end
        end
        case (chk_state)
            CPT_SEARCH:
            begin
                if (rx_edge && test_pattern_enable)
                begin
                    next_match_run = mismatch ? 6'h00 : match_run + 6'h01;
                    if (!mismatch && (match_run + 6'h01 == CPT_LOCK_MATCHES))
                    begin
                        next_chk_state = CPT_LOCKED;
                    end
                end
            end
            CPT_LOCKED:
            begin
                if (rx_edge && mismatch)
                begin
                    next_rx_out.neg = 1'b1;
                    if (err_count != '1)
                    begin
                        next_err_count = err_count + 1'b1;
                    end
                end
            end
            default:
            begin
                next_chk_state = CPT_SEARCH;
            end
        endcase
        if (!test_pattern_enable)
        begin
            next_chk_state = CPT_SEARCH;
            next_match_run = 6'h00;
            next_err_count = '0;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            chk       <= '0;
            chk_state <= CPT_SEARCH;
            match_run <= 6'h00;
            err_count <= '0;
            rx_out    <= '0;
        end
        else
        begin
            chk       <= next_chk;
            chk_state <= next_chk_state;
            match_run <= next_match_run;
            err_count <= next_err_count;
            rx_out    <= next_rx_out;
        end
    end

    assign RX_OUT_POS           = rx_out.pos;
    assign RX_NEG_VIOLATION_PIN = rx_out.neg;
    assign ERROR_COUNT          = err_count;
    assign PATTERN_LOCKED       = (chk_state == CPT_LOCKED);

endmodule : cpt_channel

`default_nettype wire

/* File: dv/cpt_channel_asserts.sv */
// Purpose: port checker for one channel's control register and pattern test
// Assumes: a shadow of the control register is rebuilt from the write strobes
// Notes: test-time checks wait 40 cycles so the first line bit after enable has landed
`default_nettype none

module cpt_channel_chk
    import cpt_pkg::*;
#(
    parameter logic [3:0] CHANNEL_NIBBLE = 4'h0
)(
    input wire logic                     REF_CLK,
    input wire logic                     RST,
    input wire logic [7:0]               CPU_ADDR,
    input wire logic [7:0]               CPU_WDATA,
    input wire logic                     CPU_WR,
    input wire logic                     CPU_RD,
    input wire logic [7:0]               CPU_RDATA,
    input wire logic                     CPU_RD_ACK,
    input wire logic                     TX_OUT_NEG,
    input wire logic                     RX_NEG_VIOLATION_PIN,
    input wire logic [CPT_ERR_WIDTH-1:0] ERROR_COUNT,
    input wire logic                     PATTERN_LOCKED,
    input wire cpt_loop_t                LOOP_MODE,
    input wire cpt_rate_t                RATE_MODE
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       hit;
    logic       en;
    logic [7:0] shadow;
    logic [7:0] next_shadow;
    logic [5:0] en_cnt;
    logic [5:0] next_en_cnt;

    assign hit = CPU_ADDR == {CHANNEL_NIBBLE, CPT_CTRL_LOW_NIBBLE};
    assign en  = shadow[CPT_TEST_EN_BIT];

    always_comb
    begin
        next_shadow = shadow;
        if (CPU_WR && hit)
            next_shadow = CPU_WDATA & CPT_CTRL_WRITE_MASK;
        next_en_cnt = (!en) ? 6'h00 : ((en_cnt == 6'h3f) ? en_cnt : en_cnt + 6'h01);
    end

    always_ff @(posedge REF_CLK)
    begin
        shadow <= RST ? 8'h00 : next_shadow;
        en_cnt <= RST ? 6'h00 : next_en_cnt;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    property p_rd_ack; CPU_RD && hit |=> CPU_RD_ACK; endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not acknowledged");
    property p_miss; !(CPU_RD && hit) |=> !CPU_RD_ACK; endproperty
    a_miss: assert property (p_miss) else $error("ack without hitting read");
    property p_rdata; CPU_RD && hit |=> CPU_RDATA == $past(shadow); endproperty
    a_rdata: assert property (p_rdata) else $error("read data wrong");
    property p_loop; LOOP_MODE == (4'h1 << {shadow[3], shadow[4]}); endproperty
    a_loop: assert property (p_loop) else $error("loop decode wrong");
    property p_rate; RATE_MODE == (shadow[2] ? 3'h4 : (shadow[1] ? 3'h2 : 3'h1)); endproperty
    a_rate: assert property (p_rate) else $error("rate decode wrong");
    property p_off; !en [*2] |-> ERROR_COUNT == 16'h0000 && !PATTERN_LOCKED; endproperty
    a_off: assert property (p_off) else $error("checker active while off");
    property p_step;
        en && $past(en) && ERROR_COUNT != $past(ERROR_COUNT)
            |-> ERROR_COUNT == $past(ERROR_COUNT) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count step not one");
    property p_search; en_cnt > 6'h28 && !PATTERN_LOCKED |-> !RX_NEG_VIOLATION_PIN; endproperty
    a_search: assert property (p_search) else $error("flag during search");
    property p_txneg; en_cnt > 6'h28 |-> !TX_OUT_NEG; endproperty
    a_txneg: assert property (p_txneg) else $error("negative rail during test");
    property p_flag;
        $rose(RX_NEG_VIOLATION_PIN) && en_cnt > 6'h28 |-> ##[0:3] $changed(ERROR_COUNT);
    endproperty
    a_flag: assert property (p_flag) else $error("flag without count");

    c_lock: cover property ($rose(PATTERN_LOCKED));
    c_err: cover property ($rose(RX_NEG_VIOLATION_PIN) && en);
    c_rd: cover property (CPU_RD && hit ##1 CPU_RD_ACK);
endmodule : cpt_channel_chk

bind cpt_channel cpt_channel_chk #(.CHANNEL_NIBBLE(CHANNEL_NIBBLE)) cpt_channel_chk_inst (
    .REF_CLK, .RST, .CPU_ADDR, .CPU_WDATA, .CPU_WR, .CPU_RD, .CPU_RDATA, .CPU_RD_ACK,
    .TX_OUT_NEG, .RX_NEG_VIOLATION_PIN, .ERROR_COUNT, .PATTERN_LOCKED, .LOOP_MODE, .RATE_MODE);

`default_nettype wire

/* File: dv/cpt_sys_model.sv */
// Purpose: system-side framer plus a line loop from transmit output to receive input
// Assumes: line clock runs free at 160 ns, phase unrelated to REF_CLK
// Notes: flip_req inverts exactly one looped receive bit
`default_nettype none

module cpt_sys_model (
    input  wire logic tx_out_pos,
    input  wire logic tx_out_neg,
    input  wire logic flip_req,
    input  wire logic neg_force,
    output logic      tx_clk,
    output logic      tx_pos,
    output logic      tx_neg,
    output logic      rx_clk,
    output logic      rx_pos,
    output logic      rx_neg
);
    timeunit 1ns;
    timeprecision 1ns;
    int   seed;
    logic flip;

    initial
    begin
        seed = 30371;
        tx_clk = 1'b0;
        tx_pos = 1'b0;
        tx_neg = 1'b0;
        flip = 1'b0;
        #3;
        forever
        begin
            #80 tx_clk = 1'b1;
            flip = flip_req;
            #80 tx_clk = 1'b0;
            tx_pos = 1'($random(seed));
            tx_neg = 1'($random(seed));
        end
    end

    // receive samples mid-bit, away from the transmit update
    assign rx_clk = ~tx_clk;
    assign rx_pos = tx_out_pos ^ flip;
    // neg_force probes the single-rail override while testing
    assign rx_neg = tx_out_neg | neg_force;
endmodule : cpt_sys_model

`default_nettype wire

/* File: dv/tb_cpt_channel.sv */
// Purpose: self-checking bench for one channel's control register and pattern test
// Assumes: channel nibble 9; the partner loops line output back to the receive pins
// Notes: the fifo cannot be filled from the pins, so only its ready level is seen
`default_nettype none

module tb_cpt_channel import cpt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] NIB  = 4'h9;
    localparam logic [7:0] CTRL = {NIB, CPT_CTRL_LOW_NIBBLE};
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] CPU_ADDR = 8'h00;
    logic [7:0] CPU_WDATA = 8'h00;
    logic CPU_WR = 1'b0;
    logic CPU_RD = 1'b0;
    logic flip_req = 1'b0;
    logic neg_force = 1'b0;
    logic [7:0] CPU_RDATA;
    logic CPU_RD_ACK, TX_READY, TX_OUT_POS, TX_OUT_NEG, RX_OUT_POS, RX_NEG_VIOLATION_PIN;
    logic PATTERN_LOCKED, tx_clk, tx_pos, tx_neg, rx_clk, rx_pos, rx_neg;
    logic [15:0] ERROR_COUNT;
    cpt_loop_t LOOP_MODE;
    cpt_rate_t RATE_MODE;
    int n_errors, n_tests, seed, mode, nbits;
    logic [1:0] w_cur, w_prev, w_old;
    logic [22:0] hist;
    logic long_seq, seen_flag, single;

    always #5 REF_CLK = ~REF_CLK;

    cpt_channel #(.CHANNEL_NIBBLE(NIB)) cpt_channel_inst (
        .REF_CLK, .RST, .CPU_ADDR, .CPU_WDATA, .CPU_WR, .CPU_RD, .CPU_RDATA, .CPU_RD_ACK,
        .TX_LINE_CLOCK(tx_clk), .TX_POSITIVE_DATA(tx_pos), .TX_NEGATIVE_DATA(tx_neg),
        .TX_READY, .TX_OUT_POS, .TX_OUT_NEG, .RX_REC_CLOCK(rx_clk), .RX_REC_POS(rx_pos),
        .RX_REC_NEG(rx_neg), .RX_OUT_POS, .RX_NEG_VIOLATION_PIN, .ERROR_COUNT,
        .PATTERN_LOCKED, .LOOP_MODE, .RATE_MODE);
    cpt_sys_model cpt_sys_model_inst (.tx_out_pos(TX_OUT_POS), .tx_out_neg(TX_OUT_NEG),
        .flip_req, .neg_force, .tx_clk, .tx_pos, .tx_neg, .rx_clk, .rx_pos, .rx_neg);

    function automatic logic [3:0] loop_exp(input logic [7:0] v);
        return 4'h1 << {v[3], v[4]};
    endfunction : loop_exp
    function automatic logic [2:0] rate_exp(input logic [7:0] v);
        return v[2] ? 3'h4 : (v[1] ? 3'h2 : 3'h1);
    endfunction : rate_exp
    function automatic logic prbs_exp(input logic [22:0] h, input logic lng);
        return lng ? h[17] ^ h[22] : h[13] ^ h[14];
    endfunction : prbs_exp

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge REF_CLK);
        CPU_ADDR = a;
        CPU_WDATA = d;
        CPU_WR = 1'b1;
        @(negedge REF_CLK);
        CPU_WR = 1'b0;
    endtask : wr
    // a miss must leave the last read data standing
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge REF_CLK);
        CPU_ADDR = a;
        CPU_RD = 1'b1;
        @(negedge REF_CLK);
        CPU_RD = 1'b0;
        check("rd_ack", CPU_RD_ACK, 16'(a == CTRL));
        check("rd_data", CPU_RDATA, exp);
    endtask : rd
    task automatic tally_and_finish();
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic wait_lock();
        int i;
        for (i = 0; i < 4000 && PATTERN_LOCKED !== 1'b1; i++)
            @(negedge REF_CLK);
        check("locked", PATTERN_LOCKED, 16'h1);
        if (PATTERN_LOCKED !== 1'b1)
            tally_and_finish();
    endtask : wait_lock

    always @(posedge tx_clk)
    begin
        w_prev <= w_cur;
        w_cur <= {tx_pos, tx_neg};
    end
    always @(negedge tx_clk)
    begin
        if (mode == 1 && nbits > 3)
        begin
            check("tx_word", {TX_OUT_POS, TX_OUT_NEG}, w_prev);
            check("rx_out", {RX_OUT_POS, RX_NEG_VIOLATION_PIN}, w_old & {1'b1, ~single});
        end
        if (mode == 2 && nbits > 1)
        begin
            check("prbs_bit", TX_OUT_POS, prbs_exp(hist, long_seq));
            check("prbs_neg", TX_OUT_NEG, 16'h0);
            if (nbits < 40)
                check("rx_single", RX_NEG_VIOLATION_PIN, 16'h0);
        end
        hist <= {hist[21:0], TX_OUT_POS};
        w_old <= w_prev;
        nbits <= nbits + 1;
    end
    always @(posedge REF_CLK)
        if (RX_NEG_VIOLATION_PIN === 1'b1 && mode == 2)
            seen_flag <= 1'b1;

    // a stalled line clock would otherwise hang the run
    initial
    begin
        #500000;
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        int i;
        logic [7:0] v;
        n_errors = 0;
        n_tests = 0;
        seed = 30371;
        mode = 0;
        nbits = 0;
        long_seq = 1'b0;
        seen_flag = 1'b0;
        repeat (3) @(negedge REF_CLK);
        RST = 1'b0;
        check("loop_rst", LOOP_MODE, 16'h1);
        check("rate_rst", RATE_MODE, 16'h1);
        check("cnt_rst", ERROR_COUNT, 16'h0);
        check("ready", TX_READY, 16'h1);
        rd(CTRL, 8'h00);
        for (i = 0; i < 16; i++)
        begin
            v = 8'($random(seed));
            v[4:1] = i[3:0];
            v[5] = 1'b0;
            wr(CTRL, v);
            rd(CTRL, v & 8'h3f);
            check("loop", LOOP_MODE, loop_exp(v));
            check("rate", RATE_MODE, rate_exp(v));
            wr({~NIB, 4'h6}, 8'h3f);
            wr({NIB, 4'h5}, 8'h3f);
            rd({NIB, 4'h5}, v & 8'h3f);
            rd(CTRL, v & 8'h3f);
        end
        for (i = 0; i < 2; i++)
        begin
            mode = 0;
            single = i[0];
            wr(CTRL, 8'(i));
            mode = 1;
            nbits = 0;
            repeat (40) @(negedge tx_clk);
        end
        for (i = 0; i < 3; i++)
        begin
            mode = 0;
            long_seq = (i == 2);
            wr(CTRL, 8'h20 | (8'h01 << i) & 8'h26);
            neg_force = 1'b1;
            wait_lock();
            seen_flag = 1'b0;
            mode = 2;
            nbits = 0;
            repeat (40) @(negedge tx_clk);
            check("no_err", ERROR_COUNT, 16'h0);
            flip_req = 1'b1;
            @(posedge tx_clk);
            @(negedge REF_CLK);
            flip_req = 1'b0;
            repeat (40) @(negedge tx_clk);
            check("err_cnt", ERROR_COUNT, 16'h3);
            check("err_pin", seen_flag, 16'h1);
            mode = 0;
            neg_force = 1'b0;
            wr(CTRL, 8'h00);
            repeat (4) @(negedge REF_CLK);
            check("off_cnt", ERROR_COUNT, 16'h0);
            check("off_lock", PATTERN_LOCKED, 16'h0);
        end
        tally_and_finish();
    end
endmodule : tb_cpt_channel

`default_nettype wire
